//--- pph_pkg.sv
package pph_pkg;

  // ==========================================================
  // widths
  localparam int SAMPLE_W = 16;
  localparam int BIN_W    = 10;
  localparam int BINS     = 1024;
  localparam int CNT_W    = 32;
  localparam int ADDR_W   = 8;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_THRESH   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLOOR    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TOTAL    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LIVE     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_REAL     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DEAD     = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_HIST_SEL = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_HIST_DAT = 8'h24;

  // ==========================================================
  // control field positions
  localparam int CTRL_EN     = 0;
  localparam int CTRL_MODE   = 1;
  localparam int CTRL_CLR    = 2;
  localparam int CTRL_G1_LSB = 4;
  localparam int CTRL_G2_LSB = 6;
  localparam int CTRL_PILEUP_REJECT_ENABLE = 8;
  localparam int CTRL_W      = 9;

  // ==========================================================
  // reset values
  localparam logic [CTRL_W-1:0]   CTRL_RST   = 9'h000;
  localparam logic [SAMPLE_W-1:0] THRESH_RST = 16'h0100;
  localparam logic [SAMPLE_W-1:0] FLOOR_RST  = 16'h0000;

  // ==========================================================
  // gate polarity codes
  localparam logic [1:0] GATE_OFF  = 2'h0;
  localparam logic [1:0] GATE_HIGH = 2'h1;
  localparam logic [1:0] GATE_LOW  = 2'h2;

  // ==========================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PK_IDLE = 3'b001,
    PK_RISE = 3'b010,
    PK_FALL = 3'b100
  } pph_state_type;

endpackage

//--- pph_hist.sv
`timescale 1ns/100ps

module pph_hist
  import pph_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              inc_valid,
  input  wire logic [BIN_W-1:0]  inc_bin,
  input  wire logic              clr_start,
  input  wire logic [BIN_W-1:0]  rd_bin,
  output logic      [CNT_W-1:0]  rd_data,
  output logic                   clr_busy
);

  logic [CNT_W-1:0] mem [BINS];
  logic             busy_reg;
  logic             busy_next;
  logic [BIN_W-1:0] ptr_reg;
  logic [BIN_W-1:0] ptr_next;

  // ==========================================================
  // clear sweep, one bin per cycle
  always_comb begin
    busy_next = busy_reg;
    ptr_next  = ptr_reg;
    if (clr_start) begin
      busy_next = 1'b1;
      ptr_next  = '0;
    end else if (busy_reg) begin
      ptr_next = ptr_reg + 1'b1;
      if (ptr_reg == BIN_W'(BINS - 1)) begin
        busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
      ptr_reg  <= '0;
    end else begin
      busy_reg <= busy_next;
      ptr_reg  <= ptr_next;
    end
  end

  // ==========================================================
  // single-cycle read-modify-write, so back-to-back peaks never collide
  always_ff @(posedge aclk) begin
    if (busy_reg) begin
      mem[ptr_reg] <= '0;
    end else if (inc_valid) begin
      mem[inc_bin] <= mem[inc_bin] + 1'b1;
    end
    rd_data <= mem[rd_bin];
  end

  assign clr_busy = busy_reg;

endmodule

//--- pph_top.sv
`timescale 1ns/100ps

module pph_top
  import pph_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire logic                gate1,
  input  wire logic                gate2,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  // ==========================================================
  // helpers
  function automatic logic gate_pass(input logic [1:0] cfg, input logic lvl);
    gate_pass = (cfg == GATE_HIGH) ? lvl : (cfg == GATE_LOW) ? !lvl : 1'b1;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  // ==========================================================
  // gate pin synchronisers: level moves once stages two and three agree
  logic [1:0] gs1_reg;
  logic [1:0] gs2_reg;
  logic [1:0] gs3_reg;
  logic [1:0] glvl_reg;
  logic [1:0] glvl_next;

  always_comb begin
    glvl_next = glvl_reg;
    for (int i = 0; i < 2; i++) begin
      if (gs2_reg[i] == gs3_reg[i]) begin
        glvl_next[i] = gs3_reg[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gs1_reg  <= '0;
      gs2_reg  <= '0;
      gs3_reg  <= '0;
      glvl_reg <= '0;
    end else begin
      gs1_reg  <= {gate2, gate1};
      gs2_reg  <= gs1_reg;
      gs3_reg  <= gs2_reg;
      glvl_reg <= glvl_next;
    end
  end

  // ==========================================================
  // registers
  logic [CTRL_W-1:0]   ctrl_reg;
  logic [CTRL_W-1:0]   ctrl_next;
  logic [SAMPLE_W-1:0] thresh_reg;
  logic [SAMPLE_W-1:0] thresh_next;
  logic [SAMPLE_W-1:0] floor_reg;
  logic [SAMPLE_W-1:0] floor_next;
  logic [BIN_W-1:0]    hsel_reg;
  logic [BIN_W-1:0]    hsel_next;
  logic                clr_pulse;
  logic                enable;
  logic                mode2;
  logic                live;

  assign enable = ctrl_reg[CTRL_EN];
  assign mode2  = ctrl_reg[CTRL_MODE];

  // ==========================================================
  // peak detector
  pph_state_type       st_reg;
  pph_state_type       st_next;
  logic [SAMPLE_W-1:0] max_reg;
  logic [SAMPLE_W-1:0] max_next;
  logic [SAMPLE_W-1:0] min_reg;
  logic [SAMPLE_W-1:0] min_next;
  logic                qual_reg;
  logic                qual_next;
  logic                pk_valid;
  logic [SAMPLE_W-1:0] pk_height;
  logic [16:0]         fall;
  logic [16:0]         rise;

  // widened so the differences never wrap
  assign fall = {1'b0, max_reg} - {1'b0, sample};
  assign rise = {1'b0, sample} - {1'b0, min_reg};

  always_comb begin
    st_next   = st_reg;
    max_next  = max_reg;
    min_next  = min_reg;
    qual_next = qual_reg;
    pk_valid  = 1'b0;
    pk_height = max_reg;
    unique case (st_reg)
      PK_IDLE: begin
        if (enable && sample > thresh_reg) begin
          st_next   = PK_RISE;
          max_next  = sample;
          qual_next = 1'b0;
        end
      end
      PK_RISE: begin
        if (sample > max_reg) begin
          max_next = sample;
        end else if (!fall[16] && fall[15:0] >= thresh_reg) begin
          st_next  = PK_FALL;
          min_next = sample;
          if (!mode2) begin
            pk_valid = 1'b1;
          end else begin
            qual_next = 1'b1;
          end
        end
        if (mode2 && sample <= thresh_reg) begin
          st_next  = PK_IDLE;
          pk_valid = qual_next;
        end
      end
      PK_FALL: begin
        if (sample <= thresh_reg) begin
          st_next  = PK_IDLE;
          pk_valid = mode2;
        end else if (sample < min_reg) begin
          min_next = sample;
        end else if (!rise[16] && rise[15:0] >= thresh_reg) begin
          // new rise: mode one restarts, mode two keeps the largest
          st_next = PK_RISE;
          if (!mode2 || sample > max_reg) begin
            max_next = sample;
          end
        end
      end
    endcase
    if (!enable) begin
      st_next = PK_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg   <= PK_IDLE;
      max_reg  <= '0;
      min_reg  <= '0;
      qual_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      max_reg  <= max_next;
      min_reg  <= min_next;
      qual_reg <= qual_next;
    end
  end

  // ==========================================================
  // acceptance, histogram and counters
  logic             gates_ok;
  logic             veto;
  logic             accept;
  logic             hist_busy;
  logic [CNT_W-1:0] hist_rd;
  logic [CNT_W-1:0] total_reg;
  logic [CNT_W-1:0] total_next;
  logic [CNT_W-1:0] live_reg;
  logic [CNT_W-1:0] live_next;
  logic [CNT_W-1:0] real_reg;
  logic [CNT_W-1:0] real_next;
  logic [CNT_W-1:0] dead_reg;
  logic [CNT_W-1:0] dead_next;

  assign gates_ok = gate_pass(ctrl_reg[CTRL_G1_LSB +: 2], glvl_reg[0]) &&
                    gate_pass(ctrl_reg[CTRL_G2_LSB +: 2], glvl_reg[1]);
  // pile-up is flagged only by the outside gate; nothing here detects it
  assign veto     = ctrl_reg[CTRL_PILEUP_REJECT_ENABLE] && glvl_reg[1];
  assign live     = enable && gates_ok && !veto && !hist_busy;
  assign accept   = pk_valid && live && pk_height > floor_reg;

  always_comb begin
    total_next = total_reg + CNT_W'(accept);
    real_next  = real_reg + CNT_W'(enable);
    live_next  = live_reg + CNT_W'(live);
    dead_next  = dead_reg + CNT_W'(enable && !live);
    if (clr_pulse) begin
      total_next = '0;
      real_next  = '0;
      live_next  = '0;
      dead_next  = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      total_reg <= '0;
      real_reg  <= '0;
      live_reg  <= '0;
      dead_reg  <= '0;
    end else begin
      total_reg <= total_next;
      real_reg  <= real_next;
      live_reg  <= live_next;
      dead_reg  <= dead_next;
    end
  end

  pph_hist u_hist (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .inc_valid (accept),
    .inc_bin   (pk_height[SAMPLE_W-1 -: BIN_W]),
    .clr_start (clr_pulse),
    .rd_bin    (hsel_reg),
    .rd_data   (hist_rd),
    .clr_busy  (hist_busy)
  );

  // ==========================================================
  // axi4-lite slave
  logic              awh_reg;
  logic              awh_next;
  logic              wh_reg;
  logic              wh_next;
  logic [ADDR_W-1:0] awa_reg;
  logic [ADDR_W-1:0] awa_next;
  logic [31:0]       wd_reg;
  logic [31:0]       wd_next;
  logic [3:0]        ws_reg;
  logic [3:0]        ws_next;
  logic              bv_reg;
  logic              bv_next;
  logic [1:0]        br_reg;
  logic [1:0]        br_next;
  logic              rv_reg;
  logic              rv_next;
  logic              rdh_reg;
  logic              rdh_next;
  logic [1:0]        rr_reg;
  logic [1:0]        rr_next;
  logic [31:0]       rd_reg;
  logic [31:0]       rd_next;
  logic [ADDR_W-1:0] ara_reg;
  logic [ADDR_W-1:0] ara_next;
  logic              do_wr;

  assign s_axi_awready = !awh_reg && !bv_reg;
  assign s_axi_wready  = !wh_reg && !bv_reg;
  assign s_axi_arready = !rv_reg && !rdh_reg;
  assign do_wr         = awh_reg && wh_reg && !bv_reg;

  always_comb begin
    awh_next    = awh_reg;
    wh_next     = wh_reg;
    awa_next    = awa_reg;
    wd_next     = wd_reg;
    ws_next     = ws_reg;
    bv_next     = bv_reg && !s_axi_bready;
    br_next     = br_reg;
    ctrl_next   = ctrl_reg;
    ctrl_next[CTRL_CLR] = 1'b0;
    thresh_next = thresh_reg;
    floor_next  = floor_reg;
    hsel_next   = hsel_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      awh_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wh_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (do_wr) begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = RESP_OKAY;
      unique case (awa_reg)
        OFS_CTRL:     ctrl_next   = CTRL_W'(merge(32'(ctrl_reg), wd_reg, ws_reg));
        OFS_THRESH:   thresh_next = SAMPLE_W'(merge(32'(thresh_reg), wd_reg, ws_reg));
        OFS_FLOOR:    floor_next  = SAMPLE_W'(merge(32'(floor_reg), wd_reg, ws_reg));
        OFS_HIST_SEL: hsel_next   = BIN_W'(merge(32'(hsel_reg), wd_reg, ws_reg));
        OFS_TOTAL, OFS_LIVE, OFS_REAL, OFS_DEAD, OFS_STATUS, OFS_HIST_DAT: ;
        default:      br_next     = RESP_SLVERR;
      endcase
    end
  end

  assign clr_pulse = ctrl_reg[CTRL_CLR];

  // read takes two cycles so the histogram word is registered first
  always_comb begin
    rdh_next = 1'b0;
    ara_next = ara_reg;
    rv_next  = rv_reg && !s_axi_rready;
    rr_next  = rr_reg;
    rd_next  = rd_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rdh_next = 1'b1;
      ara_next = s_axi_araddr;
    end
    if (rdh_reg) begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      unique case (ara_reg)
        OFS_CTRL:     rd_next = 32'(ctrl_reg);
        OFS_THRESH:   rd_next = 32'(thresh_reg);
        OFS_FLOOR:    rd_next = 32'(floor_reg);
        OFS_TOTAL:    rd_next = total_reg;
        OFS_LIVE:     rd_next = live_reg;
        OFS_REAL:     rd_next = real_reg;
        OFS_DEAD:     rd_next = dead_reg;
        OFS_STATUS:   rd_next = {25'h0000000, hist_busy, live, glvl_reg, st_reg};
        OFS_HIST_SEL: rd_next = 32'(hsel_reg);
        OFS_HIST_DAT: rd_next = hist_rd;
        default: begin
          rd_next = 32'h00000000;
          rr_next = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awh_reg    <= 1'b0;
      wh_reg     <= 1'b0;
      awa_reg    <= '0;
      wd_reg     <= '0;
      ws_reg     <= '0;
      bv_reg     <= 1'b0;
      br_reg     <= RESP_OKAY;
      ctrl_reg   <= CTRL_RST;
      thresh_reg <= THRESH_RST;
      floor_reg  <= FLOOR_RST;
      hsel_reg   <= '0;
      rdh_reg    <= 1'b0;
      ara_reg    <= '0;
      rv_reg     <= 1'b0;
      rr_reg     <= RESP_OKAY;
      rd_reg     <= '0;
    end else begin
      awh_reg    <= awh_next;
      wh_reg     <= wh_next;
      awa_reg    <= awa_next;
      wd_reg     <= wd_next;
      ws_reg     <= ws_next;
      bv_reg     <= bv_next;
      br_reg     <= br_next;
      ctrl_reg   <= ctrl_next;
      thresh_reg <= thresh_next;
      floor_reg  <= floor_next;
      hsel_reg   <= hsel_next;
      rdh_reg    <= rdh_next;
      ara_reg    <= ara_next;
      rv_reg     <= rv_next;
      rr_reg     <= rr_next;
      rd_reg     <= rd_next;
    end
  end

  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp  = br_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rresp  = rr_reg;
  assign s_axi_rdata  = rd_reg;

endmodule

//--- pph_props.sv
`timescale 1ns/100ps

// ==========================================================
// register bus handshake checks
module pph_props
  import pph_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp
);
  logic rd_bad_reg;
  logic rd_bad_next;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // refusal flag of the last accepted read address, held until the next read is taken
  always_comb begin
    rd_bad_next = rd_bad_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rd_bad_next = (s_axi_araddr > OFS_HIST_DAT) || (s_axi_araddr[1:0] != 2'h0);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_bad_reg <= 1'b0;
    end else begin
      rd_bad_reg <= rd_bad_next;
    end
  end

  // ==========================================================
  // assertions
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[2:3] s_axi_bvalid) else $error("write response missing");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid)
    else $error("read response missing");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  rd_err_a: assert property (s_axi_rvalid |-> s_axi_rresp == (rd_bad_reg ? RESP_SLVERR : RESP_OKAY))
    else $error("read response code wrong");
  rd_zero_a: assert property (s_axi_rvalid && rd_bad_reg |-> s_axi_rdata == 32'h0)
    else $error("refused read data not zero");
  rst_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("response pending after reset");

  cover property (s_axi_rvalid && rd_bad_reg);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind pph_top pph_props pph_props_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp));

//--- pph_amp.sv
`timescale 1ns/100ps

// ==========================================================
// shaping amplifier and gate circuitry
module pph_amp
  import pph_pkg::*;
(
  input  wire logic                aclk,
  output logic      [SAMPLE_W-1:0] sample,
  output logic                     gate1,
  output logic                     gate2
);
  initial begin
    sample = '0;
    gate1  = 1'b0;
    gate2  = 1'b0;
  end

  // pts[4] first; gates settle early since the device syncs them late
  task automatic play(input logic [4:0][SAMPLE_W-1:0] pts, input logic g1, input logic g2);
    int i;
    @(posedge aclk);
    gate1 <= g1;
    gate2 <= g2;
    repeat (6) @(posedge aclk);
    for (i = 4; i >= 0; i--) begin
      sample <= pts[i];
      repeat (2) @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
    gate1 <= 1'b0;
    gate2 <= 1'b0;
  endtask
endmodule

//--- testbench.sv
`timescale 1ns/100ps

module testbench
  import pph_pkg::*;
;
  logic                aclk;
  logic                aresetn;
  logic [SAMPLE_W-1:0] sample;
  logic                gate1;
  logic                gate2;
  logic [ADDR_W-1:0]   s_axi_awaddr;
  logic [ADDR_W-1:0]   s_axi_araddr;
  logic [31:0]         s_axi_wdata;
  logic [31:0]         s_axi_rdata;
  logic [1:0]          s_axi_bresp;
  logic [1:0]          s_axi_rresp;
  logic [1:0]          rsp;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready;
  logic [31:0]         v, v2, v3, v4, exp512;
  int                  n_errors, n_compared, k;
  logic [8:0]          gctl [6] = '{9'h011, 9'h011, 9'h021, 9'h101, 9'h021, 9'h041};
  logic [5:0]          g1_t = 6'h05;
  logic [5:0]          g2_t = 6'b101000;
  logic [5:0]          hit_t = 6'b110001;

  pph_top pph_top_inst (.aclk(aclk), .aresetn(aresetn), .sample(sample), .gate1(gate1),
    .gate2(gate2), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  pph_amp pph_amp_inst (.aclk(aclk), .sample(sample), .gate1(gate1), .gate2(gate2));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ==========================================================
  // checking and bus tasks
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (i == 100) begin
      n_errors++;
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (i == 100) begin
      n_errors++;
      report_and_stop();
    end
  endtask

  task automatic rc(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(name, d, e);
  endtask

  task automatic bin_is(input logic [BIN_W-1:0] b, input logic [31:0] e);
    wr(OFS_HIST_SEL, {22'h0, b}, rsp);
    rc("bin count", OFS_HIST_DAT, e);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    n_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl", OFS_CTRL, 32'h0);
    rc("thresh", OFS_THRESH, 32'h100);
    rc("floor", OFS_FLOOR, 32'h0);
    rc("total", OFS_TOTAL, 32'h0);
    rd(8'h40, v, rsp);
    check("bad read resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h44, 32'h1, rsp);
    check("bad write resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    // ram is not reset, so sweep it before counting
    wr(OFS_CTRL, 32'h4, rsp);
    for (k = 0; k < 20; k++) begin
      repeat (100) @(posedge aclk);
      rd(OFS_STATUS, v, rsp);
      if (v[6] === 1'b0) break;
    end
    if (k == 20) begin
      n_errors++;
      report_and_stop();
    end
    wr(OFS_FLOOR, 32'h2000, rsp);
    wr(OFS_CTRL, 32'h1, rsp);
    pph_amp_inst.play({16'h4000, 16'h8000, 16'h4000, 16'h0, 16'h0}, 1'b0, 1'b0);
    pph_amp_inst.play({16'h0080, 16'h0100, 16'h0080, 16'h0, 16'h0}, 1'b0, 1'b0);
    pph_amp_inst.play({16'h1000, 16'h2000, 16'h1000, 16'h0, 16'h0}, 1'b0, 1'b0);
    pph_amp_inst.play({16'h1000, 16'h2040, 16'h1000, 16'h0, 16'h0}, 1'b0, 1'b0);
    rc("total", OFS_TOTAL, 32'h2);
    bin_is(10'd512, 32'h1);
    bin_is(10'd129, 32'h1);
    bin_is(10'd128, 32'h0);
    bin_is(10'd4, 32'h0);
    pph_amp_inst.play({16'h4000, 16'h3000, 16'h6000, 16'h3000, 16'h0}, 1'b0, 1'b0);
    wr(OFS_CTRL, 32'h3, rsp);
    pph_amp_inst.play({16'h4000, 16'h3000, 16'h6000, 16'h3000, 16'h0}, 1'b0, 1'b0);
    bin_is(10'd256, 32'h1);
    bin_is(10'd384, 32'h2);
    rc("total", OFS_TOTAL, 32'h5);
    exp512 = 32'h1;
    for (k = 0; k < 6; k++) begin
      wr(OFS_CTRL, {23'h0, gctl[k]}, rsp);
      pph_amp_inst.play({16'h4000, 16'h8000, 16'h4000, 16'h0, 16'h0}, g1_t[k], g2_t[k]);
      exp512 = exp512 + hit_t[k];
      bin_is(10'd512, exp512);
    end
    rc("total", OFS_TOTAL, 32'h8);
    // gate1 idles low, so live must stall and dead grow
    wr(OFS_CTRL, 32'h11, rsp);
    rd(OFS_LIVE, v, rsp);
    rd(OFS_DEAD, v2, rsp);
    rd(OFS_LIVE, v3, rsp);
    rd(OFS_DEAD, v4, rsp);
    check("live stalled", v3, v);
    check("dead grows", {31'h0, v4 > v2}, 32'h1);
    rd(OFS_REAL, v, rsp);
    rd(OFS_REAL, v2, rsp);
    check("real grows", {31'h0, v2 > v}, 32'h1);
    wr(OFS_CTRL, 32'h0, rsp);
    rd(OFS_REAL, v, rsp);
    rd(OFS_REAL, v2, rsp);
    check("real held", v2, v);
    report_and_stop();
  end
endmodule
